// *** bench/ccsm_can_model.sv ***
`timescale 1ns/100ps

// behavioural can controller: error counters, init handshake, bus-off
module ccsm_can_model
    import ccsm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic init_req,
    input wire logic recov_req,
    input wire logic slow,
    input wire logic boff_hit,
    input wire logic [7:0] tec,
    input wire logic [7:0] rec,
    input wire logic [3:0] err,
    output ccsm_ctl_t ctl
);
    logic [4:0] tmr; // bus-off exit countdown
    logic [4:0] icnt; // init progress
    logic [4:0] dly; // answer delay, slow or prompt
    assign dly = slow ? 5'h14 : 5'h03;

    // controller status; bus-off drops only after recovery or reinit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl <= '0;
            tmr <= 5'h00;
            icnt <= 5'h00;
        end else begin
            ctl.tec <= tec;
            ctl.rec <= rec;
            {ctl.passive, ctl.overrun, ctl.tx_ovf, ctl.rx_ovf} <= err;
            ctl.active <= ctl.init_done && !ctl.bus_off;
            // init cannot finish while the controller is still bus-off
            if (!init_req)
                icnt <= 5'h00;
            else if (!ctl.bus_off && !ctl.init_done)
                icnt <= icnt + 5'h01;
            if (init_req && !ctl.bus_off && icnt == dly)
                ctl.init_done <= 1'b1;
            if (boff_hit) begin
                ctl.bus_off <= 1'b1;
                ctl.init_done <= 1'b0;
            end else if (tmr == 5'h01) begin
                ctl.bus_off <= 1'b0;
            end
            if (tmr != 5'h00)
                tmr <= tmr - 5'h01;
            else if (recov_req || (init_req && ctl.bus_off))
                tmr <= dly;
        end
    end
endmodule : ccsm_can_model

// *** bench/ccsm_monitor_tb_top.sv ***
`timescale 1ns/100ps

module ccsm_monitor_tb_top
    import ccsm_pkg::*;
;
    // table row: controller levels, register index, expected word
    typedef struct packed {
        logic [7:0] t;
        logic [7:0] r;
        logic [3:0] e;
        logic [3:0] a;
        logic [15:0] x;
    } ccsm_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1; // dropped once to test the freeze
    logic slow = 1'b1; // controller answers slowly at first
    logic boff_hit = 1'b0;
    logic [7:0] tec = 8'h00;
    logic [7:0] rec = 8'h00;
    logic [3:0] err = 4'h0; // passive, overrun, tx ovf, rx ovf
    ccsm_req_t req = '0;
    logic [15:0] rdata;
    ccsm_ctl_t ctl;
    logic ctl_init_req, recov_req, motion_allow, comm_fault;
    int errors = 0;
    int checks_done = 0;
    int recov_seen = 0; // recovery pulses seen at the controller
    ccsm_row_t rows [16] = '{
        '{8'hff, 8'h00, 4'h0, 4'h1, 16'h00ff},
        '{8'h5a, 8'ha5, 4'h0, 4'h1, 16'h005a},
        '{8'h00, 8'hff, 4'h0, 4'h2, 16'h00ff},
        '{8'h00, 8'h3c, 4'h0, 4'h2, 16'h003c},
        '{8'h00, 8'h00, 4'h4, 4'h3, 16'h0020},
        '{8'h00, 8'h00, 4'h2, 4'h3, 16'h0040},
        '{8'h00, 8'h00, 4'h1, 4'h3, 16'h0080},
        '{8'h00, 8'h00, 4'h7, 4'h3, 16'h00e0},
        '{8'h00, 8'h00, 4'h0, 4'h0, 16'h0005},
        '{8'h00, 8'h00, 4'h0, 4'h6, 16'h0000},
        '{8'h00, 8'h00, 4'h0, 4'h7, 16'h0000},
        '{8'h00, 8'h00, 4'h0, 4'h8, 16'h0000},
        '{8'h00, 8'h00, 4'h0, 4'h5, 16'h0003},
        '{8'h00, 8'h00, 4'h0, 4'h4, 16'h0004},
        '{8'h00, 8'h00, 4'h0, 4'h9, 16'h0001},
        '{8'h00, 8'h00, 4'h0, 4'ha, 16'h0000}
    };

    always #4 clk = ~clk;

    // count recovery pulses as the controller would take them
    always @(posedge clk) begin
        if (recov_req)
            recov_seen++;
    end

    ccsm_monitor u_ccsm_monitor (.clk(clk), .rst(rst), .ce(ce), .req(req),
        .rdata(rdata), .ctl(ctl), .ctl_init_req(ctl_init_req),
        .recov_req(recov_req), .motion_allow(motion_allow),
        .comm_fault(comm_fault));

    ccsm_can_model u_ccsm_can_model (.clk(clk), .rst(rst),
        .init_req(ctl_init_req), .recov_req(recov_req), .slow(slow),
        .boff_hit(boff_hit), .tec(tec), .rec(rec), .err(err), .ctl(ctl));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    // one-cycle read strobe, data stands in the following cycle only
    task automatic rd(input logic [3:0] a, input logic [15:0] x);
        @(posedge clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1 chk(rdata, x);
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : wr

    // single-cycle bus-off event at the controller
    task automatic hit_boff();
        @(posedge clk);
        boff_hit <= 1'b1;
        @(posedge clk);
        boff_hit <= 1'b0;
    endtask : hit_boff

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        errors++;
        end_sim();
    end

    initial begin
        wt(16);
        rst <= 1'b0;
        #1 chk({15'h0, ctl_init_req}, 16'h0000);
        @(posedge clk);
        #1 chk({15'h0, ctl_init_req}, 16'h0001);
        rd(4'h4, 16'h0001);
        wt(30);
        rd(4'h4, 16'h0002);
        chk({15'h0, motion_allow}, 16'h0000);
        $display("test reset and init done");
        wr(4'h9, 16'h0001);
        wt(3);
        // plain cases, last rows leave the controller clean
        foreach (rows[i]) begin
            @(posedge clk);
            tec <= rows[i].t;
            rec <= rows[i].r;
            err <= rows[i].e;
            wt(3);
            rd(rows[i].a, rows[i].x);
        end
        $display("test table done");
        // write to a read-only index must not land
        wr(4'h4, 16'hffff);
        rd(4'h4, 16'h0004);
        @(posedge clk);
        err <= 4'h8;
        wt(3);
        rd(4'h4, 16'h0005);
        rd(4'h3, 16'h0100);
        rd(4'h5, 16'h000b);
        chk({15'h0, motion_allow}, 16'h0001);
        @(posedge clk);
        err <= 4'h0;
        wt(3);
        rd(4'h4, 16'h0004);
        $display("test passive done");
        // freeze: read data and state hold while enable is low
        @(posedge clk);
        req <= '{4'h4, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        ce <= 1'b0;
        err <= 4'h8;
        wt(4);
        #1 chk(rdata, 16'h0004);
        @(posedge clk);
        err <= 4'h0;
        wt(3);
        ce <= 1'b1;
        rd(4'h4, 16'h0004);
        $display("test freeze done");
        // bus-off with automatic recovery
        wr(4'h9, 16'h0003);
        hit_boff();
        wt(3);
        #1 chk({15'h0, comm_fault}, 16'h0001);
        chk({15'h0, motion_allow}, 16'h0000);
        rd(4'h4, 16'h0006);
        rd(4'h3, 16'h0200);
        rd(4'h5, 16'h0004);
        wt(60);
        rd(4'h4, 16'h0004);
        rd(4'h6, 16'h0001);
        rd(4'h7, 16'h0001);
        rd(4'h8, 16'h0001);
        chk(recov_seen[15:0], 16'h0001);
        $display("test recovery done");
        // bus-off with recovery off: stays in fault until restart
        wr(4'h9, 16'h0001);
        @(posedge clk);
        slow <= 1'b0;
        hit_boff();
        wt(30);
        rd(4'h4, 16'h0006);
        rd(4'h7, 16'h0001);
        chk(recov_seen[15:0], 16'h0001);
        wr(4'h9, 16'h0005);
        wt(20);
        rd(4'h4, 16'h0004);
        rd(4'h6, 16'h0002);
        rd(4'h8, 16'h0002);
        rd(4'h9, 16'h0001);
        $display("test restart done");
        // mid-run reset: back to idle, counters cleared
        @(posedge clk);
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        #1 chk({15'h0, ctl_init_req}, 16'h0000);
        rd(4'h4, 16'h0001);
        rd(4'h6, 16'h0000);
        rd(4'h7, 16'h0000);
        rd(4'h8, 16'h0000);
        rd(4'h9, 16'h0000);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : ccsm_monitor_tb_top

// *** logic/ccsm_defines.svh ***
`ifndef CCSM_DEFINES_SVH
`define CCSM_DEFINES_SVH

// register word indices on the plain register port
`define CCSM_A_SIZE 4'h0
`define CCSM_A_TEC 4'h1
`define CCSM_A_REC 4'h2
`define CCSM_A_FLAGS 4'h3
`define CCSM_A_CODE 4'h4
`define CCSM_A_BITS 4'h5
`define CCSM_A_BOFF 4'h6
`define CCSM_A_RECOV 4'h7
`define CCSM_A_RESET 4'h8
`define CCSM_A_CTRL 4'h9

// fixed and reset values
`define CCSM_ENTRIES 16'h0005
`define CCSM_CNT_MAX 16'h7fff
`define CCSM_CNT_RST 16'h0000
`define CCSM_CTRL_RST 2'h0

// control register fields
`define CCSM_CB_CMDSRC 0
`define CCSM_CB_RECOV 1
`define CCSM_CB_RESTART 2

// error flag bit positions
`define CCSM_FB_OVR 5
`define CCSM_FB_TXO 6
`define CCSM_FB_RXO 7
`define CCSM_FB_PAS 8
`define CCSM_FB_BOFF 9

// controller state bit positions
`define CCSM_SB_INIT 0
`define CCSM_SB_ACT 1
`define CCSM_SB_BOFF 2
`define CCSM_SB_PAS 3

// reported state codes
`define CCSM_SC_IDLE 16'h0000
`define CCSM_SC_INIT 16'h0001
`define CCSM_SC_RO 16'h0002
`define CCSM_SC_OK 16'h0004
`define CCSM_SC_WARN 16'h0005
`define CCSM_SC_FAULT 16'h0006

`endif

// *** logic/ccsm_monitor.sv ***
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`include "ccsm_defines.svh"

module ccsm_monitor
    import ccsm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire ccsm_req_t req,
    output logic [15:0] rdata,
    input wire ccsm_ctl_t ctl,
    output logic ctl_init_req,
    output logic recov_req,
    output logic motion_allow,
    output logic comm_fault
);

    // snapshot of controller status, same clock so no synchroniser
    ccsm_ctl_t snap;
    // state machine
    ccsm_state_t st;
    ccsm_state_t next_st;
    // event counters
    logic [15:0] boff_cnt;
    logic [15:0] recov_cnt;
    logic [15:0] reset_cnt;
    // software control bits
    logic [1:0] ctrl;
    // one recovery attempt per bus-off stay
    logic recov_done;
    logic [15:0] next_rdata;

    // saturating increment, never wraps past the top
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == `CCSM_CNT_MAX) ? v : v + 16'h0001;
    endfunction : sat_inc

    // register write decode
    wire wr_ctrl = req.wr && (req.addr == `CCSM_A_CTRL);
    // restart is a write-one pulse, not stored
    wire sw_restart = wr_ctrl && req.wdata[`CCSM_CB_RESTART];
    wire cmd_src = ctrl[`CCSM_CB_CMDSRC];
    wire recov_en = ctrl[`CCSM_CB_RECOV];

    // events that move the counters
    wire enter_fault = (next_st == ccsm_st_fault) &&
                       (st != ccsm_st_fault);
    wire leave_fault = (st == ccsm_st_fault) &&
                       (next_st == ccsm_st_init);
    wire try_recov = (st == ccsm_st_fault) && recov_en &&
                     !recov_done && snap.bus_off;

    // error flag word, reserved bits tied low
    wire [15:0] flags;
    assign flags[4:0] = 5'h00;
    assign flags[`CCSM_FB_OVR] = snap.overrun;
    assign flags[`CCSM_FB_TXO] = snap.tx_ovf;
    assign flags[`CCSM_FB_RXO] = snap.rx_ovf;
    assign flags[`CCSM_FB_PAS] = snap.passive;
    assign flags[`CCSM_FB_BOFF] = snap.bus_off;
    assign flags[15:10] = 6'h00;

    // controller state bits
    wire [15:0] sbits;
    assign sbits[`CCSM_SB_INIT] = snap.init_done;
    assign sbits[`CCSM_SB_ACT] = snap.active;
    assign sbits[`CCSM_SB_BOFF] = snap.bus_off;
    assign sbits[`CCSM_SB_PAS] = snap.passive;
    assign sbits[15:4] = 12'h000;

    // state to reported code; 3 and 7 have no source
    logic [15:0] code;
    always_comb begin
        unique case (st)
            ccsm_st_idle: code = `CCSM_SC_IDLE;
            ccsm_st_init: code = `CCSM_SC_INIT;
            ccsm_st_ro: code = `CCSM_SC_RO;
            ccsm_st_ok: code = `CCSM_SC_OK;
            ccsm_st_warn: code = `CCSM_SC_WARN;
            ccsm_st_fault: code = `CCSM_SC_FAULT;
            default: code = `CCSM_SC_IDLE;
        endcase
    end

    // next state; bus-off outranks passive everywhere
    always_comb begin
        next_st = st;
        unique case (st)
            // idle lasts one enabled cycle after reset
            ccsm_st_idle: next_st = ccsm_st_init;
            // controller held in setup until it reports ready
            ccsm_st_init: begin
                if (snap.init_done)
                    next_st = cmd_src ? ccsm_st_ok : ccsm_st_ro;
            end
            // read-only link still watches for bus-off
            ccsm_st_ro: begin
                if (snap.bus_off)
                    next_st = ccsm_st_fault;
                else if (cmd_src)
                    next_st = ccsm_st_ok;
            end
            ccsm_st_ok: begin
                if (snap.bus_off)
                    next_st = ccsm_st_fault;
                else if (snap.passive)
                    next_st = ccsm_st_warn;
                else if (!cmd_src)
                    next_st = ccsm_st_ro;
            end
            ccsm_st_warn: begin
                if (snap.bus_off)
                    next_st = ccsm_st_fault;
                else if (!snap.passive)
                    next_st = ccsm_st_ok;
            end
            // leave only by reinitialising the interface
            ccsm_st_fault: begin
                if (!snap.bus_off || sw_restart)
                    next_st = ccsm_st_init;
            end
            default: next_st = ccsm_st_idle;
        endcase
    end

    // init, motion and fault outputs straight from the state register
    assign ctl_init_req = (st == ccsm_st_init);
    // motion only in clean or warning states
    assign motion_allow = (st == ccsm_st_ok) ||
                          (st == ccsm_st_warn);
    assign comm_fault = (st == ccsm_st_fault);
    // one cycle request toward the controller
    assign recov_req = try_recov && ce;

    // read mux; unmapped words read zero
    always_comb begin
        unique case (req.addr)
            `CCSM_A_SIZE: next_rdata = `CCSM_ENTRIES;
            `CCSM_A_TEC: next_rdata = {8'h00, snap.tec};
            `CCSM_A_REC: next_rdata = {8'h00, snap.rec};
            `CCSM_A_FLAGS: next_rdata = flags;
            `CCSM_A_CODE: next_rdata = code;
            `CCSM_A_BITS: next_rdata = sbits;
            `CCSM_A_BOFF: next_rdata = boff_cnt;
            `CCSM_A_RECOV: next_rdata = recov_cnt;
            `CCSM_A_RESET: next_rdata = reset_cnt;
            `CCSM_A_CTRL: next_rdata = {14'h0000, ctrl};
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after an enabled strobe; low enable holds it
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rdata <= 16'h0000;
        else if (ce)
            rdata <= req.rd ? next_rdata : 16'h0000;
    end

    // controller snapshot
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            snap <= '0;
        else if (ce)
            snap <= ctl;
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            st <= ccsm_st_idle;
        else if (ce)
            st <= next_st;
    end

    // control register, software writable
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ctrl <= `CCSM_CTRL_RST;
        else if (ce && wr_ctrl)
            ctrl <= req.wdata[1:0];
    end

    // recovery latch, rearmed on every fault entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            recov_done <= 1'b0;
        else if (ce)
            recov_done <= enter_fault ? 1'b0 : (recov_done || try_recov);
    end

    // event counters; they only rise, so nothing races a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boff_cnt <= `CCSM_CNT_RST;
            recov_cnt <= `CCSM_CNT_RST;
            reset_cnt <= `CCSM_CNT_RST;
        end else if (ce) begin
            if (enter_fault)
                boff_cnt <= sat_inc(boff_cnt);
            if (try_recov)
                recov_cnt <= sat_inc(recov_cnt);
            if (leave_fault)
                reset_cnt <= sat_inc(reset_cnt);
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire rd_tec = ce && req.rd && (req.addr == `CCSM_A_TEC);
    wire rd_rec = ce && req.rd && (req.addr == `CCSM_A_REC);

    chk_tec_read: assert property (
        rd_tec |=> rdata == {8'h00, $past(snap.tec)})
        else $error("tec read mismatch");
    chk_rec_read: assert property (
        rd_rec |=> rdata == {8'h00, $past(snap.rec)})
        else $error("rec read mismatch");
    chk_idle_init: assert property (
        (st == ccsm_st_idle) && ce |=> st == ccsm_st_init ##0
        ctl_init_req)
        else $error("idle did not go to init");
    chk_ro_no_motion: assert property (
        code == `CCSM_SC_RO |-> !motion_allow)
        else $error("motion allowed in read-only state");
    chk_no_rsvd_code: assert property (
        code != 16'h0003 && code != 16'h0007)
        else $error("reserved state code reported");
    chk_passive_warn: assert property (
        (st == ccsm_st_ok) && ce && snap.passive && !snap.bus_off
        |=> code == `CCSM_SC_WARN)
        else $error("passive did not give warning");
    chk_busoff_fault: assert property (
        (st == ccsm_st_warn) && ce && snap.bus_off
        |=> comm_fault && code == `CCSM_SC_FAULT)
        else $error("bus-off did not give fault");
    chk_flag_bits: assert property (
        ce |=> flags[9:5] == $past({ctl.bus_off, ctl.passive,
        ctl.rx_ovf, ctl.tx_ovf, ctl.overrun}))
        else $error("error flag bits wrong");
    chk_flag_rsvd: assert property (
        flags[4:0] == 5'h00 && flags[15:10] == 6'h00)
        else $error("reserved flag bits set");
    chk_boff_count: assert property (
        ce && enter_fault && boff_cnt != `CCSM_CNT_MAX
        |=> boff_cnt == $past(boff_cnt) + 16'h0001)
        else $error("bus-off count missed");
    chk_reset_count: assert property (
        ce && leave_fault && reset_cnt != `CCSM_CNT_MAX
        |=> reset_cnt == $past(reset_cnt) + 16'h0001 ##0
        ctl_init_req)
        else $error("reset count missed");
    chk_cnt_sat: assert property (
        recov_cnt <= `CCSM_CNT_MAX && boff_cnt <= `CCSM_CNT_MAX &&
        reset_cnt <= `CCSM_CNT_MAX)
        else $error("counter passed its top");

    // warning clears back to ok once passive drops
    chk_ok_clean: assert property (
        (st == ccsm_st_warn) && ce && !snap.passive && !snap.bus_off
        |=> code == `CCSM_SC_OK)
        else $error("warning did not return to ok");

    // clean state reports code 4 and lets motion through
    chk_ok_motion: assert property (
        st == ccsm_st_ok |-> motion_allow && code == `CCSM_SC_OK)
        else $error("ok state output wrong");

    // ready controller without command source lands in read-only
    chk_ro_entry: assert property (
        (st == ccsm_st_init) && ce && snap.init_done && !cmd_src
        |=> code == `CCSM_SC_RO)
        else $error("init did not go to read-only");

    // setup request only ever seen with the init code
    chk_init_code: assert property (
        ctl_init_req |-> code == `CCSM_SC_INIT)
        else $error("init request outside init state");

    // fault always blocks motion
    chk_fault_out: assert property (
        comm_fault |-> !motion_allow && code == `CCSM_SC_FAULT)
        else $error("fault outputs wrong");

    // state bits 0 and 1 follow the controller one cycle late
    chk_sbits_low: assert property (
        ce |=> sbits[1:0] == $past({ctl.active, ctl.init_done}))
        else $error("init or active state bit wrong");

    // state bits 2 and 3 follow the controller one cycle late
    chk_sbits_high: assert property (
        ce |=> sbits[3:2] == $past({ctl.passive, ctl.bus_off}))
        else $error("bus-off or passive state bit wrong");

    // each recovery attempt moves its counter once
    chk_recov_count: assert property (
        ce && try_recov && recov_cnt != `CCSM_CNT_MAX
        |=> recov_cnt == $past(recov_cnt) + 16'h0001)
        else $error("recovery count missed");

    // recovery request is a single cycle pulse
    chk_recov_once: assert property (
        recov_req |=> !recov_req)
        else $error("recovery request longer than one cycle");

    // a full counter stays full instead of wrapping
    chk_boff_sat: assert property (
        ce && enter_fault && boff_cnt == `CCSM_CNT_MAX
        |=> boff_cnt == `CCSM_CNT_MAX)
        else $error("bus-off count wrapped");

    // writes elsewhere than the control word change nothing
    chk_ctrl_only: assert property (
        ce && req.wr && (req.addr != `CCSM_A_CTRL)
        |=> ctrl == $past(ctrl))
        else $error("write to read-only word landed");

    // entry count is a constant word
    chk_size_read: assert property (
        ce && req.rd && (req.addr == `CCSM_A_SIZE)
        |=> rdata == `CCSM_ENTRIES)
        else $error("entry count read wrong");

    // read data clears after every enabled cycle without a strobe
    chk_rdata_zero: assert property (
        ce && !req.rd |=> rdata == 16'h0000)
        else $error("read data outside its cycle");

    // low enable freezes state and read data
    chk_ce_freeze: assert property (
        !ce |=> st == $past(st) && rdata == $past(rdata))
        else $error("state moved while frozen");

    cov_fault_entry: cover property (enter_fault && ce);
    cov_recovery: cover property (recov_req);
    cov_warn_back_ok: cover property (
        st == ccsm_st_warn ##1 st == ccsm_st_ok);

    // software restart out of a stuck fault
    cov_restart: cover property (ce && sw_restart && comm_fault);

    // link serving reads only
    cov_ro_state: cover property (st == ccsm_st_ro);

endmodule : ccsm_monitor

// *** logic/ccsm_pkg.sv ***
package ccsm_pkg;

    // link states, gray along idle-init-ok-warn-fault
    typedef enum logic [2:0] {
        ccsm_st_idle = 3'h0,
        ccsm_st_init = 3'h1,
        ccsm_st_ok = 3'h3,
        ccsm_st_warn = 3'h2,
        ccsm_st_fault = 3'h6,
        ccsm_st_ro = 3'h7
    } ccsm_state_t;

    // status bundle from the can protocol controller
    typedef struct packed {
        logic [7:0] tec;
        logic [7:0] rec;
        logic init_done;
        logic active;
        logic passive;
        logic bus_off;
        logic overrun;
        logic tx_ovf;
        logic rx_ovf;
    } ccsm_ctl_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ccsm_req_t;

endpackage : ccsm_pkg
